// ---- hdl/srb_bank_zero.sv ----
// lower special register bank: decode, storage, program counter and reset classes
//
// Summary of operation
// - common registers answer at their offset whatever the bank-select bits hold
// - upper program counter bits have no address; only the low byte is mapped
// - five-bit high latch fills counter bits 12:8 on a low-byte write; a jump takes only its top two bits into 12:11
// - power-on/brown-out resets and pin/watchdog resets load different register values
// - status powers up 0001 1xxx; other resets clear top three, flag cause
// - unimplemented addresses and bits read zero and ignore writes
// - port write sets the output latch; port read returns pin levels
// - indirect pointer holds eight bits, kept across non-power resets
module srb_bank_zero (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 external_reset_pin_n,
    input  wire logic                 wdt_timeout,
    input  wire srb_pkg::srb_req_s    req,
    output logic [7:0]                rdata,
    output srb_pkg::srb_ext_s         ext,
    input  wire logic [7:0]           ext_rdata,
    input  wire logic                 pc_step,
    input  wire logic                 pc_jump,
    input  wire logic [10:0]          pc_jump_addr,
    output logic [12:0]               pc,
    input  wire logic [2:0]           alu_flag_we,
    input  wire logic [2:0]           alu_flags,
    input  wire logic                 sleep_entry,
    input  wire logic                 wdt_clear,
    input  wire logic [2:0]           int_events,
    input  wire logic [3:0]           periph_events,
    input  wire logic [5:0]           first_io_port_pins,
    input  wire logic [7:0]           second_io_port_pins,
    input  wire logic [7:0]           third_io_port_pins,
    output logic [5:0]                first_io_port_out,
    output logic [7:0]                second_io_port_out,
    output logic [7:0]                third_io_port_out,
    output logic [7:0]                core_status,
    output logic [7:0]                interrupt_control,
    output logic [7:0]                peripheral_interrupt_flags,
    output srb_pkg::srb_periph_s      periph,
    output logic                      other_reset
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic [12:0]                 pc_q;
    logic [4:0]                  pchi_q;
    logic [7:0]                  status_q;
    logic [7:0]                  status_d;
    logic [7:0]                  ptr_q;
    logic [7:0]                  irqctl_q;
    logic [7:0]                  irqctl_d;
    logic [7:0]                  pir_q;
    logic [7:0]                  pir_d;
    logic [5:0]                  port1_q;
    logic [7:0]                  port2_q;
    logic [7:0]                  port3_q;
    srb_pkg::srb_periph_s        per_q;
    logic [7:0]                  rdata_q;
    logic [7:0]                  rd_mux;
    logic [8:0]                  ea;
    logic [6:0]                  off;
    logic                        common;
    logic                        local_hit;
    logic                        wr_en;
    logic [srb_pkg::PINS_W-1:0]  pins_raw;
    logic [srb_pkg::PINS_W-1:0]  pins_f;
    logic                        rst_pin_n_f;
    logic                        other_rst;
    logic                        any_rst;

    // ************************************************************
    // pin synchronisation and reset classes
    // ************************************************************
    assign pins_raw = {external_reset_pin_n, first_io_port_pins,
                       second_io_port_pins, third_io_port_pins};

    srb_pin_sync #(
        .W       (srb_pkg::PINS_W),
        .RST_VAL ({1'b1, 22'h0})
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_in  (pins_raw),
        .pin_out (pins_f)
    );

    assign rst_pin_n_f = pins_f[22];

    // non-power resets: pin held low or watchdog expiry
    assign other_rst = ~sys_rst & (~rst_pin_n_f | wdt_timeout);
    assign any_rst   = sys_rst | other_rst;
    assign other_reset = other_rst;

    // ************************************************************
    // address decode
    // ************************************************************
    // window access takes its address from the pointer
    always_comb begin
        if (req.addr == srb_pkg::OFS_WINDOW) begin
            ea = {status_q[srb_pkg::ST_IBS], ptr_q};
        end else begin
            ea = {status_q[srb_pkg::ST_UBS:srb_pkg::ST_LBS], req.addr};
        end
    end

    assign off = ea[6:0];

    // registers present in every bank
    always_comb begin
        unique case (off)
            srb_pkg::OFS_WINDOW,
            srb_pkg::OFS_PCLO,
            srb_pkg::OFS_STATUS,
            srb_pkg::OFS_PTR,
            srb_pkg::OFS_PCHI,
            srb_pkg::OFS_IRQCTL: common = 1'b1;
            default:             common = 1'b0;
        endcase
    end

    // bank zero offsets up to 1F and the common registers are handled here, the rest goes to data memory
    assign local_hit = common | ((ea[8:7] == 2'b00) & (off <= srb_pkg::OFS_SFR_TOP));
    // no storage behind the window itself
    assign wr_en = req.wr & local_hit & (off != srb_pkg::OFS_WINDOW);

    // data memory request for non-local addresses, direct or through the window
    assign ext.addr  = ea;
    assign ext.wr    = req.wr & ~local_hit;
    assign ext.rd    = req.rd & ~local_hit;
    assign ext.wdata = req.wdata;

    // ************************************************************
    // program counter and its high latch
    // ************************************************************
    // only the low byte is addressable; the latch feeds the upper bits
    always_ff @(posedge clk) begin
        if (any_rst) begin
            pc_q <= '0;
        end else if (wr_en && off == srb_pkg::OFS_PCLO) begin
            pc_q <= {pchi_q, req.wdata};
        end else if (pc_jump) begin
            pc_q <= {pchi_q[4:3], pc_jump_addr};
        end else if (pc_step) begin
            pc_q <= pc_q + 13'h0001;
        end
    end

    // high latch, five bits, cleared on every reset
    always_ff @(posedge clk) begin
        if (any_rst) begin
            pchi_q <= '0;
        end else if (wr_en && off == srb_pkg::OFS_PCHI) begin
            pchi_q <= req.wdata[srb_pkg::PROGRAM_COUNTER_HIGH_LATCH_W-1:0];
        end
    end

    // ************************************************************
    // core status
    // ************************************************************
    // write, then arithmetic flag updates, then sleep/watchdog flags
    always_comb begin
        status_d = status_q;
        if (wr_en && off == srb_pkg::OFS_STATUS) begin
            status_d = (status_q & ~srb_pkg::STATUS_WR_MASK)
                     | (req.wdata & srb_pkg::STATUS_WR_MASK);
        end
        for (int i = 0; i < 3; i++) begin
            if (alu_flag_we[i]) begin
                status_d[i] = alu_flags[i];
            end
        end
        if (sleep_entry) begin
            status_d[srb_pkg::ST_TOF] = 1'b1;
            status_d[srb_pkg::ST_PDF] = 1'b0;
        end else if (wdt_clear) begin
            status_d[srb_pkg::ST_TOF] = 1'b1;
            status_d[srb_pkg::ST_PDF] = 1'b1;
        end
    end

    // power-up value, or cause flags kept/updated on other resets
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_q <= srb_pkg::STATUS_POR;
        end else if (other_rst) begin
            status_q[7:5] <= 3'b000;
            if (wdt_timeout) begin
                status_q[srb_pkg::ST_TOF] <= 1'b0;
            end
        end else begin
            status_q <= status_d;
        end
    end

    // ************************************************************
    // indirect pointer
    // ************************************************************
    // kept across non-power resets
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ptr_q <= srb_pkg::ZERO8;
        end else if (!other_rst && wr_en && off == srb_pkg::OFS_PTR) begin
            ptr_q <= req.wdata;
        end
    end

    // ************************************************************
    // interrupt control and peripheral flags
    // ************************************************************
    // hardware events win over a same-cycle software clear
    always_comb begin
        irqctl_d = irqctl_q;
        if (wr_en && off == srb_pkg::OFS_IRQCTL) begin
            irqctl_d = req.wdata;
        end
        irqctl_d[2:0] = irqctl_d[2:0] | int_events;
        pir_d = pir_q;
        if (wr_en && off == srb_pkg::OFS_PIR) begin
            pir_d = req.wdata & srb_pkg::PIR_MASK;
        end
        pir_d[3:0] = pir_d[3:0] | periph_events;
    end

    // interrupt control keeps only its lowest flag on other resets
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqctl_q <= srb_pkg::ZERO8;
        end else if (other_rst) begin
            irqctl_q <= irqctl_q & srb_pkg::IRQCTL_KEEP;
        end else begin
            irqctl_q <= irqctl_d;
        end
    end

    // peripheral flags clear on every reset class
    always_ff @(posedge clk) begin
        if (any_rst) begin
            pir_q <= srb_pkg::ZERO8;
        end else begin
            pir_q <= pir_d;
        end
    end

    // ************************************************************
    // port output latches
    // ************************************************************
    // latches hold through non-power resets
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port1_q <= '0;
            port2_q <= srb_pkg::ZERO8;
            port3_q <= srb_pkg::ZERO8;
        end else if (!other_rst && wr_en) begin
            if (off == srb_pkg::OFS_PORT1) begin
                port1_q <= req.wdata[5:0];
            end
            if (off == srb_pkg::OFS_PORT2) begin
                port2_q <= req.wdata;
            end
            if (off == srb_pkg::OFS_PORT3) begin
                port3_q <= req.wdata;
            end
        end
    end

    // ************************************************************
    // peripheral registers
    // ************************************************************
    // one process owns the whole struct; timer 0/1 counts and buffers survive non-power resets, t2cnt clears
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            per_q <= '0;
        end else if (other_rst) begin
            per_q.t2cnt  <= srb_pkg::ZERO8;
            per_q.t2ctl  <= srb_pkg::ZERO8;
            per_q.serctl <= srb_pkg::ZERO8;
            per_q.ccpcon <= srb_pkg::ZERO8;
        end else if (wr_en) begin
            unique case (off)
                srb_pkg::OFS_T0CNT:  per_q.t0cnt  <= req.wdata;
                srb_pkg::OFS_T1L:    per_q.t1l    <= req.wdata;
                srb_pkg::OFS_T1H:    per_q.t1h    <= req.wdata;
                srb_pkg::OFS_T1CTL:  per_q.t1ctl  <= req.wdata & srb_pkg::T1CTL_MASK;
                srb_pkg::OFS_T2CNT:  per_q.t2cnt  <= req.wdata;
                srb_pkg::OFS_T2CTL:  per_q.t2ctl  <= req.wdata & srb_pkg::T2CTL_MASK;
                srb_pkg::OFS_SERBUF: per_q.serbuf <= req.wdata;
                srb_pkg::OFS_SERCTL: per_q.serctl <= req.wdata;
                srb_pkg::OFS_CCPL:   per_q.ccpl   <= req.wdata;
                srb_pkg::OFS_CCPH:   per_q.ccph   <= req.wdata;
                srb_pkg::OFS_CCPCON: per_q.ccpcon <= req.wdata & srb_pkg::CCPCON_MASK;
                default:             ;
            endcase
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    // ports read pins; gaps and the window itself read zero
    always_comb begin
        unique case (off)
            srb_pkg::OFS_T0CNT:  rd_mux = per_q.t0cnt;
            srb_pkg::OFS_PCLO:   rd_mux = pc_q[7:0];
            srb_pkg::OFS_STATUS: rd_mux = status_q;
            srb_pkg::OFS_PTR:    rd_mux = ptr_q;
            srb_pkg::OFS_PORT1:  rd_mux = {2'b00, pins_f[21:16]};
            srb_pkg::OFS_PORT2:  rd_mux = pins_f[15:8];
            srb_pkg::OFS_PORT3:  rd_mux = pins_f[7:0];
            srb_pkg::OFS_PCHI:   rd_mux = {3'b000, pchi_q};
            srb_pkg::OFS_IRQCTL: rd_mux = irqctl_q;
            srb_pkg::OFS_PIR:    rd_mux = pir_q;
            srb_pkg::OFS_T1L:    rd_mux = per_q.t1l;
            srb_pkg::OFS_T1H:    rd_mux = per_q.t1h;
            srb_pkg::OFS_T1CTL:  rd_mux = per_q.t1ctl;
            srb_pkg::OFS_T2CNT:  rd_mux = per_q.t2cnt;
            srb_pkg::OFS_T2CTL:  rd_mux = per_q.t2ctl;
            srb_pkg::OFS_SERBUF: rd_mux = per_q.serbuf;
            srb_pkg::OFS_SERCTL: rd_mux = per_q.serctl;
            srb_pkg::OFS_CCPL:   rd_mux = per_q.ccpl;
            srb_pkg::OFS_CCPH:   rd_mux = per_q.ccph;
            srb_pkg::OFS_CCPCON: rd_mux = per_q.ccpcon;
            default:             rd_mux = srb_pkg::ZERO8;
        endcase
    end

    // read data registered one cycle after the request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= srb_pkg::ZERO8;
        end else if (req.rd) begin
            rdata_q <= local_hit ? rd_mux : ext_rdata;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rdata                      = rdata_q;
    assign pc                         = pc_q;
    assign core_status                = status_q;
    assign interrupt_control          = irqctl_q;
    assign peripheral_interrupt_flags = pir_q;
    assign first_io_port_out          = port1_q & srb_pkg::PORT1_MASK[5:0];
    assign second_io_port_out         = port2_q;
    assign third_io_port_out          = port3_q;
    assign periph                     = per_q;

endmodule : srb_bank_zero

// ---- hdl/srb_pin_sync.sv ----
// three-stage pin synchroniser with second/third stage agreement filter
module srb_pin_sync #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);

    // ************************************************************
    // per-bit stages
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic [srb_pkg::SYNC_STAGES-1:0] stage_q;
            logic                            out_q;

            // shift chain; stage 0 feeds only stage 1
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    stage_q <= {srb_pkg::SYNC_STAGES{RST_VAL[i]}};
                end else begin
                    stage_q <= {stage_q[srb_pkg::SYNC_STAGES-2:0], pin_in[i]};
                end
            end

            // accept a level only once the last two stages agree
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    out_q <= RST_VAL[i];
                end else if (stage_q[1] == stage_q[2]) begin
                    out_q <= stage_q[2];
                end
            end

            assign pin_out[i] = out_q;
        end
    endgenerate

endmodule : srb_pin_sync

// ---- hdl/srb_pkg.sv ----
// shared offsets, field positions, reset values and carrier types of bank zero
package srb_pkg;

    // ************************************************************
    // register offsets within a bank
    // ************************************************************
    localparam logic [6:0] OFS_WINDOW  = 7'h00;
    localparam logic [6:0] OFS_T0CNT   = 7'h01;
    localparam logic [6:0] OFS_PCLO    = 7'h02;
    localparam logic [6:0] OFS_STATUS  = 7'h03;
    localparam logic [6:0] OFS_PTR     = 7'h04;
    localparam logic [6:0] OFS_PORT1   = 7'h05;
    localparam logic [6:0] OFS_PORT2   = 7'h06;
    localparam logic [6:0] OFS_PORT3   = 7'h07;
    localparam logic [6:0] OFS_PCHI    = 7'h0A;
    localparam logic [6:0] OFS_IRQCTL  = 7'h0B;
    localparam logic [6:0] OFS_PIR     = 7'h0C;
    localparam logic [6:0] OFS_T1L     = 7'h0E;
    localparam logic [6:0] OFS_T1H     = 7'h0F;
    localparam logic [6:0] OFS_T1CTL   = 7'h10;
    localparam logic [6:0] OFS_T2CNT   = 7'h11;
    localparam logic [6:0] OFS_T2CTL   = 7'h12;
    localparam logic [6:0] OFS_SERBUF  = 7'h13;
    localparam logic [6:0] OFS_SERCTL  = 7'h14;
    localparam logic [6:0] OFS_CCPL    = 7'h15;
    localparam logic [6:0] OFS_CCPH    = 7'h16;
    localparam logic [6:0] OFS_CCPCON  = 7'h17;
    localparam logic [6:0] OFS_SFR_TOP = 7'h1F;

    // ************************************************************
    // core status field positions
    // ************************************************************
    localparam int ST_IBS = 7;
    localparam int ST_UBS = 6;
    localparam int ST_LBS = 5;
    localparam int ST_TOF = 4;
    localparam int ST_PDF = 3;

    // ************************************************************
    // reset values and implemented-bit masks
    // ************************************************************
    localparam logic [7:0] ZERO8          = 8'h00;
    localparam logic [7:0] STATUS_POR     = 8'h18;
    localparam logic [7:0] STATUS_WR_MASK = 8'hE7;
    localparam logic [7:0] IRQCTL_KEEP    = 8'h01;
    localparam logic [7:0] PIR_MASK       = 8'hCF;
    localparam logic [7:0] T1CTL_MASK     = 8'h3F;
    localparam logic [7:0] T2CTL_MASK     = 8'h7F;
    localparam logic [7:0] CCPCON_MASK    = 8'h3F;
    localparam logic [7:0] PORT1_MASK     = 8'h3F;
    localparam int         PROGRAM_COUNTER_HIGH_LATCH_W       = 5;
    localparam int         PC_W           = 13;
    localparam int         PINS_W         = 23;
    localparam int         SYNC_STAGES    = 3;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic [6:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } srb_req_s;

    typedef struct packed {
        logic [8:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } srb_ext_s;

    typedef struct packed {
        logic [7:0] t0cnt;
        logic [7:0] t1l;
        logic [7:0] t1h;
        logic [7:0] t1ctl;
        logic [7:0] t2cnt;
        logic [7:0] t2ctl;
        logic [7:0] serbuf;
        logic [7:0] serctl;
        logic [7:0] ccpl;
        logic [7:0] ccph;
        logic [7:0] ccpcon;
    } srb_periph_s;

endpackage : srb_pkg

// ---- tb/special_register_bank_zero_tb_top.sv ----
// self-checking bench for the lower special register bank
module special_register_bank_zero_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, pin_n, wdt, step, jump, sleep;
    logic [10:0] jaddr;
    logic [7:0]  pins, ext_rd, rdata, p2out, p3out;
    logic [5:0]  p1out;
    logic [3:0]  pev;
    logic [12:0] pc;
    srb_pkg::srb_req_s rq;
    srb_pkg::srb_ext_s ext, ext_seen;
    int n_fail = 0;
    int n_compared = 0;
    logic [6:0]  zofs [7] = '{7'h11, 7'h12, 7'h14, 7'h17, 7'h0C, 7'h0A, 7'h02};
    logic [22:0] wtab [12] = '{{7'h0A, 8'hFF, 8'h1F}, {7'h10, 8'hFF, 8'h3F}, {7'h12, 8'hFF, 8'h7F},
        {7'h14, 8'hA5, 8'hA5}, {7'h17, 8'hFF, 8'h3F}, {7'h0C, 8'h0F, 8'h0F}, {7'h08, 8'hFF, 8'h00},
        {7'h09, 8'hFF, 8'h00}, {7'h0D, 8'hFF, 8'h00}, {7'h18, 8'hFF, 8'h00}, {7'h1F, 8'hFF, 8'h00},
        {7'h11, 8'h5A, 8'h5A}};
    srb_bank_zero dut_u (.clk(clk), .sys_rst(sys_rst), .external_reset_pin_n(pin_n), .wdt_timeout(wdt), .req(rq),
        .rdata(rdata), .ext(ext), .ext_rdata(ext_rd), .pc_step(step), .pc_jump(jump), .pc_jump_addr(jaddr), .pc(pc),
        .alu_flag_we(3'h0), .alu_flags(3'h0), .sleep_entry(sleep), .wdt_clear(1'b0), .int_events(3'h0),
        .periph_events(pev), .first_io_port_pins(pins[5:0]), .second_io_port_pins(pins), .third_io_port_pins(pins),
        .first_io_port_out(p1out), .second_io_port_out(p2out), .third_io_port_out(p3out), .core_status(),
        .interrupt_control(), .peripheral_interrupt_flags(), .periph(), .other_reset());
    // free-running core clock
    always #4 clk = ~clk;
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one write, strobe lowered with an idle cycle after
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        rq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk);
        rq.wr = 1'b0;
        @(negedge clk);
    endtask : wr
    // one read, data compared half a cycle after the taking edge
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        rq = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        #1 ext_seen = ext;
        @(negedge clk);
        rq.rd = 1'b0;
        chk({5'h00, rdata}, {5'h00, exp});
        @(negedge clk);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic complete_run();
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    // main sequence
    initial begin
        {clk, sys_rst, pin_n, wdt, step, jump, sleep} = 7'h30;
        {jaddr, pins, ext_rd, pev} = '0;
        rq = '0;
        cyc(6);
        sys_rst = 1'b0;
        rd(srb_pkg::OFS_STATUS, srb_pkg::STATUS_POR);
        foreach (zofs[i]) rd(zofs[i], 8'h00);
        foreach (wtab[i]) begin
            wr(wtab[i][22:16], wtab[i][15:8]);
            rd(wtab[i][22:16], wtab[i][7:0]);
        end
        $display("test reset values and unimplemented bits done");
        wr(srb_pkg::OFS_PCLO, 8'h34);
        chk(pc, 13'h1F34);
        step = 1'b1;
        cyc(1);
        step = 1'b0;
        chk(pc, 13'h1F35);
        wr(srb_pkg::OFS_PCHI, 8'h18);
        jaddr = 11'h123;
        jump = 1'b1;
        cyc(1);
        jump = 1'b0;
        chk(pc, 13'h1923);
        rd(srb_pkg::OFS_PCLO, 8'h23);
        pins = 8'hC3;
        wr(srb_pkg::OFS_PORT2, 8'h3C);
        chk({5'h00, p2out}, 13'h003C);
        wr(srb_pkg::OFS_PORT1, 8'hFF);
        chk({7'h00, p1out}, 13'h003F);
        wr(srb_pkg::OFS_PORT3, 8'hA5);
        chk({5'h00, p3out}, 13'h00A5);
        cyc(4);
        rd(srb_pkg::OFS_PORT2, 8'hC3);
        wr(srb_pkg::OFS_STATUS, 8'h20);
        wr(srb_pkg::OFS_PCHI, 8'h05);
        rd(srb_pkg::OFS_PCHI, 8'h05);
        rd(srb_pkg::OFS_STATUS, 8'h38);
        wr(srb_pkg::OFS_STATUS, 8'h00);
        wr(srb_pkg::OFS_PTR, 8'h30);
        ext_rd = 8'h96;
        rd(srb_pkg::OFS_WINDOW, 8'h96);
        chk({3'h0, ext_seen.rd, ext_seen.addr}, 13'h0230);
        wr(srb_pkg::OFS_PTR, 8'h0A);
        rd(srb_pkg::OFS_WINDOW, 8'h05);
        $display("test counter, ports, banks and window done");
        wr(srb_pkg::OFS_PIR, 8'h00);
        pev = 4'h4;
        cyc(1);
        pev = 4'h0;
        rd(srb_pkg::OFS_PIR, 8'h04);
        sleep = 1'b1;
        cyc(1);
        sleep = 1'b0;
        rd(srb_pkg::OFS_STATUS, 8'h10);
        wr(srb_pkg::OFS_IRQCTL, 8'hFF);
        wdt = 1'b1;
        cyc(1);
        wdt = 1'b0;
        chk(pc, 13'h0000);
        rd(srb_pkg::OFS_STATUS, 8'h00);
        rd(srb_pkg::OFS_PTR, 8'h0A);
        rd(srb_pkg::OFS_PIR, 8'h00);
        rd(srb_pkg::OFS_T2CNT, 8'h00);
        rd(srb_pkg::OFS_IRQCTL, 8'h01);
        wr(srb_pkg::OFS_STATUS, 8'h20);
        pin_n = 1'b0;
        cyc(8);
        pin_n = 1'b1;
        cyc(6);
        chk({5'h00, p2out}, 13'h003C);
        rd(srb_pkg::OFS_STATUS, 8'h00);
        rd(srb_pkg::OFS_PTR, 8'h0A);
        $display("test reset classes done");
        complete_run();
    end
endmodule : special_register_bank_zero_tb_top

// ---- tb/srb_bank_zero_monitor.sv ----
// concurrent checks on register port, program counter and reset classes of bank zero
module srb_bank_zero_monitor (
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire srb_pkg::srb_req_s    req,
    input wire logic [7:0]           rdata,
    input wire srb_pkg::srb_ext_s    ext,
    input wire logic                 pc_step,
    input wire logic                 pc_jump,
    input wire logic [10:0]          pc_jump_addr,
    input wire logic [12:0]          pc,
    input wire logic [7:0]           core_status,
    input wire logic [7:0]           second_io_port_out,
    input wire srb_pkg::srb_periph_s periph,
    input wire logic                 other_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // accepted write to the counter low byte
    sequence s_pcl_write;
        req.wr && req.addr == srb_pkg::OFS_PCLO && !other_reset;
    endsequence
    a_pcl_load: assert property (s_pcl_write |=> pc[7:0] == $past(req.wdata))
        else $error("counter low byte not loaded");
    a_pc_jump: assert property (pc_jump && !pc_step && !req.wr && !other_reset
        |=> pc[10:0] == $past(pc_jump_addr)) else $error("jump target not loaded");
    a_pc_step: assert property (pc_step && !pc_jump && !req.wr && !other_reset
        |=> pc == $past(pc) + 13'h0001) else $error("counter did not advance");
    a_por_status: assert property ($fell(sys_rst) |-> core_status[7:3] == 5'h03)
        else $error("status power-up value wrong");
    a_other_status: assert property (other_reset |=> core_status[7:5] == 3'h0)
        else $error("status bank bits kept over reset");
    a_other_clear: assert property (other_reset |=> pc == 13'h0000 && periph.t2cnt == 8'h00
        && periph.t2ctl == 8'h00 && periph.serctl == 8'h00 && periph.ccpcon == 8'h00) else $error("not cleared");
    a_port_kept: assert property (other_reset |=> $stable(second_io_port_out))
        else $error("port latch changed in reset");
    a_unimpl_zero: assert property (req.rd && req.addr inside {[7'h18:7'h1F]} && core_status[6:5] == 2'h0
        && !other_reset |=> rdata == 8'h00) else $error("unimplemented read not zero");
    a_common_local: assert property (req.wr && req.addr == srb_pkg::OFS_PCHI |-> !ext.wr)
        else $error("common register went external");
endmodule : srb_bank_zero_monitor

bind srb_bank_zero srb_bank_zero_monitor mon_u (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .ext(ext),
    .pc_step(pc_step), .pc_jump(pc_jump), .pc_jump_addr(pc_jump_addr), .pc(pc), .core_status(core_status),
    .second_io_port_out(second_io_port_out), .periph(periph), .other_reset(other_reset));
